/* rtl/oad_pkg.sv */
// Constants and types shared by the operand address decoder and its register slave
// Behaviour
// RULE_01 - Codes 00-07 select register by size
// RULE_02 - Codes 0C-0F post-increment, 4 cycles, 2 accesses
// RULE_03 - Codes 10-17 add signed disp8 to word register
// RULE_04 - Codes 18-1B add disp16 to word register
// RULE_05 - 1E is PC plus disp16, 1F direct
// RULE_06 - 1C/1D use word register 0/1 plus 7
// RULE_07 - Accumulator is 32 bits, sized lanes
// RULE_08 - Marked loads copy lower half upward first
// RULE_09 - Upper half cleared or sign filled
// RULE_10 - Byte loads clear or sign bits 15:8
// RULE_11 - Short I/O form reaches 000000-0000FF only
// RULE_12 - Cycles are base plus operand correction
// RULE_13 - Word-boundary fetch costs +2 internal, +3 external
// RULE_14 - Byte fetch on 8-bit bus costs +3
// RULE_15 - Internal odd word +2, odd long +4
// RULE_16 - 16-bit bus penalties by alignment
// RULE_17 - 8-bit bus byte +1, word +4, long +8
// RULE_18 - External accesses add ready wait cycles
// RULE_19 - Intermittent mode suspends clock per access
// RULE_20 - Intermittent cost adds accesses times wait
// RULE_21 - Software avoids RMW on split-meaning addresses
// RULE_22 - Core keeps I, S, T, N, Z, V, C flags
// RULE_23 - Extension bytes follow code, little-endian
package oad_pkg;
    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_EXT = 8'h04;
    localparam logic [7:0] OFS_GPR_SEL = 8'h08;
    localparam logic [7:0] OFS_GPR_DATA = 8'h0C;
    localparam logic [7:0] OFS_PC = 8'h10;
    localparam logic [7:0] OFS_EA = 8'h14;
    localparam logic [7:0] OFS_COST = 8'h18;
    localparam logic [7:0] OFS_ACC = 8'h1C;
    localparam logic [7:0] OFS_LOAD = 8'h20;
    localparam logic [7:0] OFS_FLAGS = 8'h24;
    localparam logic [7:0] OFS_FLAG_OP = 8'h28;
    localparam logic [7:0] OFS_IO = 8'h2C;
    // ----------------------------------------------------------------
    // Field positions of the control word and the load word
    // ----------------------------------------------------------------
    localparam int CTRL_CODE_LSB = 0; // 5-bit ea code
    localparam int CTRL_SIZE_LSB = 8; // 2-bit operand size
    localparam int CTRL_REGION_LSB = 12; // 2-bit memory region
    localparam int CTRL_BASE_LSB = 16; // 8-bit base cycles
    localparam int CTRL_BASERG_LSB = 24; // 3-bit base register accesses
    localparam int CTRL_INTM_BIT = 28;
    localparam int CTRL_WSEL_LSB = 29; // 2-bit intermittent wait select
    localparam int LOAD_LH_LSB = 0; // 2-bit LH action
    localparam int LOAD_AH_LSB = 2; // 2-bit AH action
    // ----------------------------------------------------------------
    // Encodings and reset values
    // ----------------------------------------------------------------
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [6:0] FLAGS_RST = 7'h00;
    localparam logic [4:0] EA_IDX_LO = 5'h1C;
    localparam logic [4:0] EA_IDX_HI = 5'h1D;
    localparam logic [4:0] EA_PCREL = 5'h1E;
    localparam logic [4:0] EA_DIRECT = 5'h1F;
    localparam logic [2:0] IDX_REG = 3'h7;
    localparam logic [7:0] FILL_ZERO = 8'h00;
    localparam logic [7:0] FILL_ONES = 8'hFF;
    localparam logic [7:0] PEN_FETCH_INT = 8'h02;
    localparam logic [7:0] PEN_FETCH_EXT = 8'h03;
    localparam logic [7:0] PEN_ADDR_4 = 8'h04;
    localparam logic [7:0] PEN_ADDR_2 = 8'h02;
    localparam logic [7:0] PEN_ADDR_1 = 8'h01;
    typedef enum logic [1:0] {SZ_BYTE = 2'b00, SZ_WORD = 2'b01, SZ_LONG = 2'b10} oad_size_t;
    typedef enum logic [1:0] {RG_REG = 2'b00, RG_INT = 2'b01, RG_EXT16 = 2'b10,
                              RG_EXT8 = 2'b11} oad_region_t;
    typedef enum logic [1:0] {AH_KEEP = 2'b00, AH_COPY = 2'b01, AH_ZERO = 2'b10,
                              AH_SIGN = 2'b11} oad_ah_t;
    typedef enum logic [1:0] {LH_KEEP = 2'b00, LH_ZERO = 2'b01, LH_SIGN = 2'b10} oad_lh_t;
endpackage

/* rtl/oad_core.sv */
// Operand address decode, accumulator load and cycle cost engine behind an AHB-Lite slave
//
// Added by the designer: the AHB-Lite register port and the placing of the registers.
module oad_core
#(
    parameter int WAIT_W = 8
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    input wire logic [WAIT_W-1:0] ready_waits_i,
    output logic [3:0] ext_bytes_o,
    output logic [15:0] cycles_o
);
    import oad_pkg::*;

    // ----------------------------------------------------------------
    // Bus slave: address phase capture
    // ----------------------------------------------------------------
    logic wr_pend_ff;
    logic [7:0] wr_ofs_ff;
    logic [7:0] rd_ofs_ff;
    logic rd_pend_ff;
    // Size is not decoded: every register is one whole word
    wire take_w = hsel_i & htrans_i[1] & hready_i;

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wr_pend_ff <= 1'b0;
            rd_pend_ff <= 1'b0;
            wr_ofs_ff <= 8'h00;
            rd_ofs_ff <= 8'h00;
        end
        else
        begin
            wr_pend_ff <= take_w & hwrite_i;
            rd_pend_ff <= take_w & ~hwrite_i;
            wr_ofs_ff <= haddr_i[7:0];
            rd_ofs_ff <= haddr_i[7:0];
        end
    end

    // Zero-wait slave with fixed OKAY answer
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;

    // ----------------------------------------------------------------
    // Software registers
    // ----------------------------------------------------------------
    logic [31:0] ctrl_ff;
    logic [31:0] ext_ff;
    logic [2:0] gsel_ff;
    logic [15:0] gpr_ff [0:7];
    logic [15:0] pc_ff;
    logic [31:0] acc_ff;
    logic [31:0] load_ff;
    logic [6:0] flags_ff;
    logic [23:0] ea_ff;
    logic [7:0] io_ff;

    wire wr_ctrl_w = wr_pend_ff & (wr_ofs_ff == OFS_CTRL);
    wire wr_ext_w = wr_pend_ff & (wr_ofs_ff == OFS_EXT);
    wire wr_gsel_w = wr_pend_ff & (wr_ofs_ff == OFS_GPR_SEL);
    wire wr_gdat_w = wr_pend_ff & (wr_ofs_ff == OFS_GPR_DATA);
    wire wr_pc_w = wr_pend_ff & (wr_ofs_ff == OFS_PC);
    wire wr_load_w = wr_pend_ff & (wr_ofs_ff == OFS_LOAD);
    wire wr_fop_w = wr_pend_ff & (wr_ofs_ff == OFS_FLAG_OP);
    wire wr_io_w = wr_pend_ff & (wr_ofs_ff == OFS_IO);

    // Decoded control fields
    wire [4:0] code_w = ctrl_ff[CTRL_CODE_LSB +: 5];
    wire [1:0] size_w = ctrl_ff[CTRL_SIZE_LSB +: 2];
    wire [1:0] region_w = ctrl_ff[CTRL_REGION_LSB +: 2];
    wire [7:0] base_w = ctrl_ff[CTRL_BASE_LSB +: 8];
    wire [2:0] base_rg_w = ctrl_ff[CTRL_BASERG_LSB +: 3];
    wire intm_w = ctrl_ff[CTRL_INTM_BIT];
    wire [1:0] wsel_w = ctrl_ff[CTRL_WSEL_LSB +: 2];

    // ----------------------------------------------------------------
    // Effective address decode
    // ----------------------------------------------------------------
    // Extension bytes sit low byte first right after the code byte
    wire [7:0] disp8_w = ext_ff[7:0]; // RULE_23
    wire [15:0] disp16_w = {ext_ff[15:8], ext_ff[7:0]}; // RULE_23
    wire [15:0] sx8_w = {{8{disp8_w[7]}}, disp8_w};
    wire [15:0] rw_i_w = gpr_ff[code_w[2:0]];
    wire [15:0] rw_j_w = gpr_ff[{1'b0, code_w[1:0]}];
    wire [15:0] rw_idx_w = gpr_ff[IDX_REG];
    wire is_reg_w = (code_w[4:3] == 2'b00); // RULE_01
    wire is_ind_w = (code_w[4:2] == 3'b010);
    wire is_inc_w = (code_w[4:2] == 3'b011); // RULE_02
    wire is_d8_w = (code_w[4:3] == 2'b10); // RULE_03
    wire is_d16_w = (code_w[4:2] == 3'b110); // RULE_04
    wire is_idx_w = (code_w == EA_IDX_LO) | (code_w == EA_IDX_HI); // RULE_06
    wire [15:0] idx_base_w = code_w[0] ? gpr_ff[1] : gpr_ff[0];

    logic [15:0] ea_w;
    logic [3:0] nbytes_w;
    logic [7:0] ea_cyc_w;
    logic [2:0] ea_rg_w;
    always_comb
    begin
        ea_w = 16'h0000;
        nbytes_w = 4'h0;
        ea_cyc_w = 8'h00;
        ea_rg_w = 3'd0;
        if (is_reg_w)
        begin
            // Register direct: the address names the register slot, cost lives in base
            ea_w = {13'h0000, code_w[2:0]}; // RULE_01
        end
        else if (is_ind_w)
        begin
            ea_w = rw_j_w;
            ea_cyc_w = 8'h02;
            ea_rg_w = 3'd1;
        end
        else if (is_inc_w)
        begin
            ea_w = rw_j_w; // RULE_02
            ea_cyc_w = 8'h04;
            ea_rg_w = 3'd2;
        end
        else if (is_d8_w)
        begin
            ea_w = rw_i_w + sx8_w; // RULE_03
            nbytes_w = 4'h1;
            ea_cyc_w = 8'h02;
            ea_rg_w = 3'd1;
        end
        else if (is_d16_w)
        begin
            ea_w = rw_j_w + disp16_w; // RULE_04
            nbytes_w = 4'h2;
            ea_cyc_w = 8'h02;
            ea_rg_w = 3'd1;
        end
        else if (is_idx_w)
        begin
            ea_w = idx_base_w + rw_idx_w; // RULE_06
            ea_cyc_w = 8'h04;
            ea_rg_w = 3'd2;
        end
        else if (code_w == EA_PCREL)
        begin
            ea_w = pc_ff + disp16_w; // RULE_05
            nbytes_w = 4'h2;
            ea_cyc_w = 8'h02;
        end
        else
        begin
            ea_w = disp16_w; // RULE_05
            nbytes_w = 4'h2;
            ea_cyc_w = 8'h01;
        end
    end

    // ----------------------------------------------------------------
    // Operand access correction
    // ----------------------------------------------------------------
    // Alignment is judged on the decoded address; operands in the register region never pay
    wire odd_w = ea_w[0];
    wire [7:0] szmul_w = (size_w == SZ_LONG) ? 8'h02 : 8'h01;
    logic [7:0] pen_w;
    always_comb
    begin
        pen_w = 8'h00;
        unique case (region_w)
            RG_REG: pen_w = 8'h00;
            RG_INT: pen_w = (odd_w && size_w != SZ_BYTE) ? PEN_ADDR_2 * szmul_w : 8'h00; // RULE_15
            RG_EXT16: pen_w = (size_w == SZ_BYTE) ? PEN_ADDR_1 : // RULE_16
                              (odd_w ? PEN_ADDR_4 * szmul_w : PEN_ADDR_1 * szmul_w);
            RG_EXT8: pen_w = (size_w == SZ_BYTE) ? PEN_ADDR_1 : PEN_ADDR_4 * szmul_w; // RULE_17
        endcase
    end

    // Fetch penalty, worst case: per word crossing or per byte on 8-bit bus
    wire [3:0] ibytes_w = 4'h1 + nbytes_w;
    wire [7:0] fetch_w = (region_w == RG_EXT8) ? PEN_FETCH_EXT * {4'h0, ibytes_w} : // RULE_14
                         (region_w == RG_EXT16) ? PEN_FETCH_EXT : PEN_FETCH_INT; // RULE_13
    wire ext_w = region_w[1];
    // Cast keeps the wait count at eight bits whatever WAIT_W is
    wire [7:0] waits_w = ext_w ? 8'(ready_waits_i) : 8'h00; // RULE_18
    // Intermittent suspension: 1, 2, 4 or 8 cycles per access
    wire [3:0] susp_w = 4'h1 << wsel_w; // RULE_19
    wire [3:0] acc_cnt_w = {1'b0, base_rg_w} + {1'b0, ea_rg_w};
    wire [7:0] intm_cyc_w = intm_w ? {4'h0, acc_cnt_w} * {4'h0, susp_w} : 8'h00; // RULE_20
    wire [15:0] total_w = {8'h00, base_w} + {8'h00, is_reg_w ? 8'h00 : ea_cyc_w}
                        + {8'h00, pen_w} + {8'h00, fetch_w} + {8'h00, waits_w}
                        + {8'h00, intm_cyc_w}; // RULE_12

    // ----------------------------------------------------------------
    // Accumulator load path
    // ----------------------------------------------------------------
    wire [1:0] lh_w = load_ff[LOAD_LH_LSB +: 2];
    wire [1:0] ah_w = load_ff[LOAD_AH_LSB +: 2];
    logic [15:0] new_lo_w;
    logic [15:0] new_hi_w;
    always_comb
    begin
        new_lo_w = hwdata_i[15:0]; // RULE_07
        if (size_w == SZ_BYTE && lh_w == LH_ZERO)
            new_lo_w = {FILL_ZERO, hwdata_i[7:0]}; // RULE_10
        else if (size_w == SZ_BYTE && lh_w == LH_SIGN)
            new_lo_w = {hwdata_i[7] ? FILL_ONES : FILL_ZERO, hwdata_i[7:0]}; // RULE_10
        else if (size_w == SZ_BYTE)
            new_lo_w = {acc_ff[15:8], hwdata_i[7:0]};
        new_hi_w = acc_ff[31:16];
        if (size_w == SZ_LONG)
            new_hi_w = hwdata_i[31:16]; // RULE_07
        else
        begin
            unique case (ah_w)
                AH_KEEP: new_hi_w = acc_ff[31:16];
                AH_COPY: new_hi_w = acc_ff[15:0]; // RULE_08
                AH_ZERO: new_hi_w = {FILL_ZERO, FILL_ZERO}; // RULE_09
                AH_SIGN: new_hi_w = {2{new_lo_w[15] ? FILL_ONES : FILL_ZERO}}; // RULE_09
            endcase
        end
    end
    wire [15:0] acc_lower_word = acc_ff[15:0];
    wire [15:0] acc_upper_word = acc_ff[31:16];
    wire wr_acc_w = wr_pend_ff & (wr_ofs_ff == OFS_ACC);

    // Flag update: bits set first, then cleared, then toggled by software op
    wire [6:0] fl_next_w = ((flags_ff | hwdata_i[6:0]) & ~hwdata_i[14:8]) ^ hwdata_i[22:16];

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ctrl_ff <= CTRL_RST;
            ext_ff <= 32'h0000_0000;
            gsel_ff <= 3'd0;
            pc_ff <= 16'h0000;
            acc_ff <= 32'h0000_0000;
            load_ff <= 32'h0000_0000;
            flags_ff <= FLAGS_RST;
            ea_ff <= 24'h00_0000;
            io_ff <= 8'h00;
        end
        else
        begin
            if (wr_ctrl_w) ctrl_ff <= hwdata_i;
            if (wr_ext_w) ext_ff <= hwdata_i;
            if (wr_gsel_w) gsel_ff <= hwdata_i[2:0];
            if (wr_pc_w) pc_ff <= hwdata_i[15:0];
            if (wr_load_w) load_ff <= hwdata_i;
            if (wr_acc_w) acc_ff <= {new_hi_w, new_lo_w}; // RULE_08
            if (wr_fop_w) flags_ff <= fl_next_w; // RULE_22
            // Short I/O form: high address bytes forced to zero
            if (wr_io_w) io_ff <= hwdata_i[7:0]; // RULE_11
            ea_ff <= {8'h00, ea_w};
        end
    end

    // Word registers; post-increment happens when software commits the access
    wire commit_w = wr_pend_ff & (wr_ofs_ff == OFS_EA);
    wire [15:0] inc_w = (size_w == SZ_LONG) ? 16'h0004 : (size_w == SZ_WORD) ? 16'h0002
                      : 16'h0001;
    // Only word registers 0 to 3 can post-increment
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_gpr
            always_ff @(posedge clk_i or posedge rst_i)
            begin
                if (rst_i)
                    gpr_ff[gi] <= 16'h0000;
                else if (wr_gdat_w && gsel_ff == 3'(gi))
                    gpr_ff[gi] <= hwdata_i[15:0];
                else if (commit_w && is_inc_w && code_w[1:0] == 2'(gi) && gi < 4)
                    gpr_ff[gi] <= gpr_ff[gi] + inc_w; // RULE_02
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Read mux and outputs
    // ----------------------------------------------------------------
    logic [31:0] rd_w;
    always_comb
    begin
        unique case (rd_ofs_ff)
            OFS_CTRL: rd_w = ctrl_ff;
            OFS_EXT: rd_w = ext_ff;
            OFS_GPR_SEL: rd_w = {29'h0, gsel_ff};
            OFS_GPR_DATA: rd_w = {16'h0000, gpr_ff[gsel_ff]};
            OFS_PC: rd_w = {16'h0000, pc_ff};
            OFS_EA: rd_w = {ea_ff[23:0], 4'h0, nbytes_w};
            OFS_COST: rd_w = {16'h0000, total_w};
            OFS_ACC: rd_w = {acc_upper_word, acc_lower_word};
            OFS_LOAD: rd_w = load_ff;
            OFS_FLAGS: rd_w = {25'h0, flags_ff};
            OFS_IO: rd_w = {24'h00_0000, io_ff};
            default: rd_w = 32'h0000_0000;
        endcase
    end
    assign hrdata_o = rd_pend_ff ? rd_w : 32'h0000_0000;
    assign ext_bytes_o = nbytes_w;
    assign cycles_o = total_w;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    inc_cost_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_02
        is_inc_w |-> ea_cyc_w == 8'h04 && ea_rg_w == 3'd2 && nbytes_w == 4'h0)
        else $error("post-increment cost wrong");
    d8_ext_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_03
        is_d8_w |-> nbytes_w == 4'h1 && ea_w == rw_i_w + sx8_w)
        else $error("disp8 decode wrong");
    d16_ext_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_04
        is_d16_w |-> nbytes_w == 4'h2 && ea_rg_w == 3'd1)
        else $error("disp16 decode wrong");
    direct_ea_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_05
        code_w == EA_DIRECT |-> ea_w == disp16_w && ea_rg_w == 3'd0)
        else $error("direct address wrong");
    reg_dir_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_01
        is_reg_w |-> nbytes_w == 4'h0 && ea_rg_w == 3'd0)
        else $error("register direct cost wrong");
    pc_rel_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_05
        code_w == EA_PCREL |-> ea_w == pc_ff + disp16_w && nbytes_w == 4'h2)
        else $error("pc relative address wrong");
    copy_hi_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_08
        wr_acc_w && size_w != SZ_LONG && ah_w == AH_COPY
        |=> acc_ff[31:16] == $past(acc_ff[15:0]))
        else $error("upper half not copied");
    // Lanes are judged on the value after the load edge
    long_ld_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_07
        wr_acc_w && size_w == SZ_LONG |=> acc_ff == $past(hwdata_i))
        else $error("long load not whole");
    sign_hi_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_09
        wr_acc_w && size_w != SZ_LONG && ah_w == AH_SIGN
        |=> acc_ff[31:16] == {16{acc_ff[15]}})
        else $error("upper half not sign filled");
    byte_zero_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_10
        wr_acc_w && size_w == SZ_BYTE && lh_w == LH_ZERO |=> acc_ff[15:8] == 8'h00)
        else $error("byte load not zero extended");
    int_odd_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_15
        region_w == RG_INT && odd_w && size_w == SZ_LONG |-> pen_w == 8'h04)
        else $error("internal odd long penalty");
    e16_odd_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_16
        region_w == RG_EXT16 && odd_w && size_w == SZ_LONG |-> pen_w == 8'h08)
        else $error("ext16 odd long penalty");
    e8_word_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_17
        region_w == RG_EXT8 && size_w == SZ_WORD |-> pen_w == 8'h04)
        else $error("ext8 word penalty");
    intm_add_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_20
        !intm_w |-> intm_cyc_w == 8'h00)
        else $error("suspension outside intermittent mode");
    inc_wb_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_02
        commit_w && is_inc_w && !wr_gdat_w
        |=> gpr_ff[$past(code_w[1:0])] == $past(rw_j_w) + $past(inc_w))
        else $error("post-increment missing");
    // Main scenarios that the bench should reach
    cov_inc_c: cover property (@(posedge clk_i) commit_w && is_inc_w);
    cov_copy_c: cover property (@(posedge clk_i) wr_acc_w && ah_w == AH_COPY);
    cov_intm_c: cover property (@(posedge clk_i) intm_w && region_w == RG_EXT8);
    cov_idx_c: cover property (@(posedge clk_i) is_idx_w && rd_pend_ff);
    cov_odd_c: cover property (@(posedge clk_i) odd_w && region_w == RG_EXT16);
endmodule

/* dv/oad_bus_model.sv */
// Far-side model that answers external data bus accesses with ready waits
module oad_bus_model
(
    input wire logic clk_i,
    input wire logic slow_i,
    input wire logic [7:0] slow_waits_i,
    output logic [7:0] ready_waits_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // A prompt bus adds no waits, a slow one stretches every external access
    always_ff @(posedge clk_i)
    begin
        ready_waits_o <= slow_i ? slow_waits_i : 8'h00;
    end
endmodule

/* dv/testbench.sv */
// Self-checking bench for the operand address decoder and cost engine
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import oad_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic slow = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [7:0] slow_w = 8'h05;
    logic [31:0] hrdata, rd, rd_smp;
    logic [15:0] cycles, exp_c;
    logic [7:0] waits;
    logic [3:0] ext_bytes;
    logic hreadyout, hresp;
    int err_total = 0;
    int check_count = 0;
    int cyc = 0;
    logic [4:0] ea_code [6] = '{5'h10, 5'h18, 5'h1D, 5'h1E, 5'h1F, 5'h0D};
    logic [31:0] ea_ext [6] = '{32'h80, 32'h234, 32'h0, 32'h100, 32'hBEEF, 32'h0};
    logic [15:0] ea_adr [6] = '{16'h0F80, 16'h1234, 16'h2011, 16'h4100, 16'hBEEF, 16'h2001};
    logic [1:0] acc_sz [9] = '{2'h1, 2'h1, 2'h1, 2'h1, 2'h0, 2'h0, 2'h0, 2'h2, 2'h0};
    logic [3:0] acc_ld [9] = '{4'h4, 4'h4, 4'hC, 4'h8, 4'h2, 4'h1, 4'h5, 4'h0, 4'h0};
    logic [31:0] acc_wd [9] = '{32'h1234, 32'h5678, 32'h8001, 32'h8001, 32'h80, 32'h1F5,
        32'h12, 32'hDEADBEEF, 32'h11};
    logic [31:0] acc_ex [9] = '{32'h1234, 32'h12345678, 32'hFFFF8001, 32'h8001, 32'hFF80,
        32'hF5, 32'hF50012, 32'hDEADBEEF, 32'hDEADBE11};

    oad_core #(.WAIT_W(8)) oad_core_inst (.clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
        .hwdata_i(hwdata), .hready_i(hreadyout), .hrdata_o(hrdata), .hreadyout_o(hreadyout),
        .hresp_o(hresp), .ready_waits_i(waits), .ext_bytes_o(ext_bytes), .cycles_o(cycles));
    oad_bus_model oad_bus_model_inst (.clk_i(clk_i), .slow_i(slow), .slow_waits_i(slow_w),
        .ready_waits_o(waits));

    // 25 MHz clock; read data captured at the edge that ends the data phase
    always #20 clk_i = ~clk_i;
    always @(posedge clk_i) rd_smp <= hrdata;

    // ------------------------------------------------------------
    // Expected values
    // ------------------------------------------------------------
    function automatic logic [3:0] nb(input logic [4:0] c);
        return (c[4:3] == 2'h2) ? 4'h1 : (c[4:2] == 3'h6 || c >= EA_PCREL) ? 4'h2 : 4'h0;
    endfunction

    function automatic logic [31:0] ctl(input logic [4:0] c, input logic [1:0] sz, rg,
        input logic [7:0] b, input logic [2:0] ba, input logic im, input logic [1:0] ws);
        return {1'b0, ws, im, 1'b0, ba, b, 2'h0, rg, 2'h0, sz, 3'h0, c};
    endfunction

    // Total cost: base, mode, operand penalty, fetch, ready waits, suspension
    function automatic logic [15:0] cost(input logic [4:0] c, input logic [1:0] sz, rg,
        input logic odd, input logic [7:0] base, input logic [2:0] ba, input logic im,
        input logic [1:0] ws, input logic [7:0] w);
        int ec;
        int ea;
        int pen;
        int fet;
        ec = (c < 5'h0C || (c >= 5'h10 && c < 5'h1C) || c == EA_PCREL) ? 2 : 4;
        ea = (ec == 2) ? 1 : 2;
        if (c < 5'h08) ec = 0;
        if (c < 5'h08 || c >= EA_PCREL) ea = 0;
        if (c == EA_DIRECT) ec = 1;
        case (rg)
            RG_INT: pen = odd ? 2 * sz : 0;
            RG_EXT16: pen = (sz == SZ_BYTE) ? 1 : odd ? 4 * sz : sz;
            RG_EXT8: pen = (sz == SZ_BYTE) ? 1 : 4 * sz;
            default: pen = 0;
        endcase
        fet = (rg == RG_EXT16) ? 3 : (rg == RG_EXT8) ? 3 * (1 + nb(c)) : 2;
        return 16'(base + ec + pen + fet + (rg[1] ? w : 0) + (im ? (ba + ea) << ws : 0));
    endfunction

    // ------------------------------------------------------------
    // Bus access and checking
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Plain single reads and writes only, never a locked read-modify-write
    task automatic bus(input logic wr, input logic [7:0] ofs, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h0, ofs};
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge clk_i);
        while (hreadyout !== 1'b1) @(posedge clk_i);
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge clk_i);
        while (hreadyout !== 1'b1) @(posedge clk_i);
        #1 rd = rd_smp;
    endtask

    task automatic wr(input logic [7:0] ofs, input logic [31:0] wd);
        bus(1'b1, ofs, wd);
    endtask

    task automatic rdc(input logic [7:0] ofs, input logic [31:0] exp);
        bus(1'b0, ofs, 32'h0);
        chk(rd, exp);
    endtask

    task automatic conclude();
        if (err_total == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Hang guard well above the expected run length
    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_total++;
            conclude();
        end
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        rdc(OFS_CTRL, CTRL_RST);
        rdc(OFS_FLAGS, 32'h0);
        rdc(OFS_COST, 32'h2);
        wr(8'h30, 32'hFFFFFFFF);
        rdc(8'h30, 32'h0);
        // Every mode on internal memory: extension count and cost
        for (int c = 0; c < 32; c++)
        begin
            wr(OFS_CTRL, ctl(5'(c), SZ_BYTE, RG_INT, 8'h03, 3'h1, 1'b0, 2'h0));
            chk({28'h0, ext_bytes}, {28'h0, nb(5'(c))});
            exp_c = cost(5'(c), SZ_BYTE, RG_INT, 1'b0, 8'h03, 3'h1, 1'b0, 2'h0, 8'h00);
            rdc(OFS_COST, {16'h0, exp_c});
        end
        // Operand penalties by region, size and alignment; slow bus on odd cases
        for (int r = 0; r < 4; r++)
            for (int s = 0; s < 3; s++)
                for (int o = 0; o < 2; o++)
                begin
                    slow <= o[0];
                    wr(OFS_EXT, o[0] ? 32'h1235 : 32'h1234);
                    wr(OFS_CTRL, ctl(EA_DIRECT, 2'(s), 2'(r), 8'h05, 3'h0, 1'b0, 2'h0));
                    exp_c = cost(EA_DIRECT, 2'(s), 2'(r), o[0], 8'h05, 3'h0, 1'b0, 2'h0,
                        o[0] ? slow_w : 8'h00);
                    rdc(OFS_COST, {16'h0, exp_c});
                    chk({16'h0, cycles}, {16'h0, exp_c});
                    chk({31'h0, hresp}, 32'h0);
                end
        // Intermittent mode at every wait select
        slow <= 1'b0;
        for (int w = 0; w < 4; w++)
        begin
            wr(OFS_CTRL, ctl(5'h0C, SZ_WORD, RG_REG, 8'h02, 3'h1, 1'b1, 2'(w)));
            exp_c = cost(5'h0C, SZ_WORD, RG_REG, 1'b0, 8'h02, 3'h1, 1'b1, 2'(w), 8'h00);
            rdc(OFS_COST, {16'h0, exp_c});
        end
        // Address forming, little-endian extension bytes, then a post-increment
        wr(OFS_GPR_SEL, 32'h0);
        wr(OFS_GPR_DATA, 32'h1000);
        wr(OFS_GPR_SEL, 32'h1);
        wr(OFS_GPR_DATA, 32'h2001);
        wr(OFS_GPR_SEL, 32'h7);
        wr(OFS_GPR_DATA, 32'h10);
        wr(OFS_PC, 32'h4000);
        for (int i = 0; i < 6; i++)
        begin
            wr(OFS_EXT, ea_ext[i]);
            wr(OFS_CTRL, ctl(ea_code[i], SZ_WORD, RG_INT, 8'h00, 3'h0, 1'b0, 2'h0));
            rdc(OFS_EA, {8'h0, ea_adr[i], 4'h0, nb(ea_code[i])});
        end
        wr(OFS_EA, 32'h0);
        wr(OFS_GPR_SEL, 32'h1);
        rdc(OFS_GPR_DATA, 32'h2003);
        // Accumulator loads through every upper and lower half action
        for (int i = 0; i < 9; i++)
        begin
            wr(OFS_CTRL, ctl(5'h00, acc_sz[i], RG_REG, 8'h00, 3'h0, 1'b0, 2'h0));
            wr(OFS_LOAD, {28'h0, acc_ld[i]});
            wr(OFS_ACC, acc_wd[i]);
            rdc(OFS_ACC, acc_ex[i]);
        end
        // Short I/O byte and flag set, clear and toggle
        wr(OFS_IO, 32'h1A5);
        rdc(OFS_IO, 32'hA5);
        wr(OFS_FLAG_OP, 32'h55);
        rdc(OFS_FLAGS, 32'h55);
        wr(OFS_FLAG_OP, 32'h500);
        rdc(OFS_FLAGS, 32'h50);
        wr(OFS_FLAG_OP, 32'h7F0000);
        rdc(OFS_FLAGS, 32'h2F);
        conclude();
    end
endmodule
